// ---- common/wave_guard_pkg.sv ----
// Constants shared by the waveform extension top and its fault unit.
// Assumes one 8-bit register port with byte-wide registers at the offsets below.
package wave_guard_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] OFS_EXT_CTRL = 4'h0;
  localparam logic [3:0] OFS_FAULT_MASK = 4'h2;
  localparam logic [3:0] OFS_FAULT_CTRL = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DT_BOTH = 4'h6;
  localparam logic [3:0] OFS_DT_BOTH_BUF = 4'h7;
  localparam logic [3:0] OFS_DT_LOW = 4'h8;
  localparam logic [3:0] OFS_DT_HIGH = 4'h9;
  localparam logic [3:0] OFS_DT_LOW_BUF = 4'hA;
  localparam logic [3:0] OFS_DT_HIGH_BUF = 4'hB;
  localparam logic [3:0] OFS_OVERRIDE_EN = 4'hC;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int CTRL_PATTERN_BIT = 5;
  localparam int CTRL_COMMON_BIT = 4;
  localparam logic [7:0] CTRL_WR_MASK = 8'h3F;
  localparam int FCTRL_DBG_DIS_BIT = 4;
  localparam int FCTRL_MODE_BIT = 2;
  localparam logic [7:0] FCTRL_WR_MASK = 8'h17;
  localparam int STAT_FLAG_BIT = 2;
  localparam int STAT_HIGH_BUFV_BIT = 1;
  localparam int STAT_LOW_BUFV_BIT = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ****************************************************************
  // Fault action codes and restore modes
  // ****************************************************************
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_CLEAR_DIR = 2'h3;
  localparam logic MODE_LATCHED = 1'b0;

  typedef enum logic {FS_NORMAL, FS_FAULT} fault_state_t;

endpackage

// ---- common/fault_link_if.sv ----
// Carries setup, triggers and results between the top and its fault unit.
// Assumes both ends share core_clk_i.
`timescale 1ns/1ps
interface fault_link_if;
  logic [7:0] event_mask;
  logic [1:0] action_sel;
  logic restart_mode;
  logic debug_break_fault_disable;
  logic flag_clear;
  logic update;
  logic fault_hold;
  logic flag;
  logic fault_enter;
  logic fault_leave;

  modport top
  (
    output event_mask, action_sel, restart_mode, debug_break_fault_disable, flag_clear, update,
    input fault_hold, flag, fault_enter, fault_leave
  );
  modport unit
  (
    input event_mask, action_sel, restart_mode, debug_break_fault_disable, flag_clear, update,
    output fault_hold, flag, fault_enter, fault_leave
  );
endinterface

// ---- verilog/fault_unit.sv ----
// Event-driven fault detector with latched and cycle-by-cycle restore.
// Assumes events and break request are synchronous to core_clk_i.
`timescale 1ns/1ps
module fault_unit #(
  parameter int EVENT_CHANNELS = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [EVENT_CHANNELS-1:0] fault_event_i,
  input wire logic debug_break_i,
  fault_link_if.unit link
);

  // ****************************************************************
  // Trigger
  // ****************************************************************
  logic prot_en;
  logic dbg_trig;
  logic trig;
  logic release_ok;
  wave_guard_pkg::fault_state_t state_q;
  wave_guard_pkg::fault_state_t state_d;
  logic flag_q;
  logic flag_d;

  // Reserved action codes disable protection as code 00 does
  assign prot_en = (link.action_sel == wave_guard_pkg::ACT_CLEAR_DIR);
  assign dbg_trig = debug_break_i & ~link.debug_break_fault_disable;
  assign trig = prot_en & ((|(fault_event_i & link.event_mask)) | dbg_trig);

  // ****************************************************************
  // Flag and state
  // ****************************************************************
  // Set wins over a software clear in the same cycle
  assign flag_d = trig | (flag_q & ~link.flag_clear);
  // Latched mode also needs the flag gone; the break acts like any fault
  assign release_ok = ~trig & ((link.restart_mode != wave_guard_pkg::MODE_LATCHED) | ~flag_q);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      wave_guard_pkg::FS_NORMAL:
      begin
        if (trig)
        begin
          state_d = wave_guard_pkg::FS_FAULT;
        end
      end
      wave_guard_pkg::FS_FAULT:
      begin
        if (release_ok & link.update)
        begin
          state_d = wave_guard_pkg::FS_NORMAL;
        end
      end
    endcase
  end

  // Runs purely on the peripheral clock, no processor needed
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= wave_guard_pkg::FS_NORMAL;
      flag_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      flag_q <= flag_d;
    end
  end

  // Hold is registered, so the action lands one cycle after the event
  assign link.fault_hold = (state_q == wave_guard_pkg::FS_FAULT);
  assign link.flag = flag_q;
  assign link.fault_enter = (state_q == wave_guard_pkg::FS_NORMAL) & trig;
  assign link.fault_leave = (state_q == wave_guard_pkg::FS_FAULT) & (state_d == wave_guard_pkg::FS_NORMAL);

endmodule // fault_unit

// ---- verilog/waveform_pattern_fault_guard.sv ----
// Waveform extension: pattern generation, dead-time channel selection
// and event-driven fault protection between a timer and an I/O port.
// Assumes the timer supplies compare waveforms and a one-cycle UPDATE pulse,
// the port applies direction clear/restore masks and output overrides.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module waveform_pattern_fault_guard #(
  parameter int CHANNELS = 4,
  parameter int PINS = 8,
  parameter int EVENT_CHANNELS = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_lock_i,
  input wire logic [CHANNELS-1:0] compare_wave_i,
  input wire logic update_i,
  input wire logic [EVENT_CHANNELS-1:0] fault_event_i,
  input wire logic debug_break_i,
  input wire logic [PINS-1:0] port_dir_i,
  output logic [CHANNELS-1:0] deadtime_channel_en_o,
  output logic [CHANNELS-1:0] deadtime_wave_o,
  output logic [7:0] deadtime_low_o,
  output logic [7:0] deadtime_high_o,
  output logic [PINS-1:0] pin_override_o,
  output logic [PINS-1:0] pin_value_o,
  output logic port_out_load_o,
  output logic [PINS-1:0] port_out_data_o,
  output logic [PINS-1:0] dir_clear_o,
  output logic [PINS-1:0] dir_restore_o,
  output logic timer_error_set_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Each channel owns a pin pair: channel x drives pins 2x and 2x+1
  function automatic logic [PINS-1:0] channel_pins(input logic [CHANNELS-1:0] ch);
    logic [PINS-1:0] pins;
    pins = '0;
    for (int i = 0; i < CHANNELS; i++)
    begin
      pins[2*i] = ch[i];
      pins[2*i+1] = ch[i];
    end
    return pins;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  fault_link_if link ();

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] fault_mask_q;
  logic [7:0] fault_mask_d;
  logic [7:0] fault_ctrl_q;
  logic [7:0] fault_ctrl_d;
  logic [7:0] dt_low_q;
  logic [7:0] dt_low_d;
  logic [7:0] dt_high_q;
  logic [7:0] dt_high_d;
  logic [7:0] dt_low_buf_q;
  logic [7:0] dt_low_buf_d;
  logic [7:0] dt_high_buf_q;
  logic [7:0] dt_high_buf_d;
  logic low_bufv_q;
  logic low_bufv_d;
  logic high_bufv_q;
  logic high_bufv_d;
  logic [PINS-1:0] override_en_q;
  logic [PINS-1:0] override_en_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic port_load_q;
  logic [PINS-1:0] dir_restore_q;
  logic timer_err_q;

  logic pattern_mode_en;
  logic common_waveform_sel;
  logic [CHANNELS-1:0] deadtime_channel_en;
  logic [PINS-1:0] enabled_pins;
  logic unlocked;
  logic override_writable;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_fctrl;
  logic wr_status;
  logic wr_both;
  logic wr_both_buf;
  logic wr_low;
  logic wr_high;
  logic wr_low_buf;
  logic wr_high_buf;
  logic wr_override;
  logic load_low;
  logic load_high;
  logic [7:0] status_byte;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  // Pattern mode wins over the dead-time channel enables
  assign pattern_mode_en = ctrl_q[wave_guard_pkg::CTRL_PATTERN_BIT];
  assign common_waveform_sel = ctrl_q[wave_guard_pkg::CTRL_COMMON_BIT];
  assign deadtime_channel_en = ctrl_q[CHANNELS-1:0];
  assign enabled_pins = channel_pins(deadtime_channel_en);

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Lock covers control, override enable and event mask only
  assign unlocked = ~ext_lock_i;
  // Override enable writes are refused while a fault is flagged or held
  assign override_writable = unlocked & ~link.flag & ~link.fault_hold;
  assign wr_ctrl = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_EXT_CTRL) & unlocked;
  assign wr_mask = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_FAULT_MASK) & unlocked;
  assign wr_fctrl = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_FAULT_CTRL);
  assign wr_status = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_STATUS);
  assign wr_both = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_DT_BOTH);
  assign wr_both_buf = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_DT_BOTH_BUF);
  assign wr_low = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_DT_LOW);
  assign wr_high = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_DT_HIGH);
  assign wr_low_buf = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_DT_LOW_BUF);
  assign wr_high_buf = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_DT_HIGH_BUF);
  assign wr_override = reg_wr_i & (reg_addr_i == wave_guard_pkg::OFS_OVERRIDE_EN) & override_writable;

  // ****************************************************************
  // Fault unit hookup
  // ****************************************************************
  assign link.event_mask = fault_mask_q;
  assign link.action_sel = fault_ctrl_q[1:0];
  assign link.restart_mode = fault_ctrl_q[wave_guard_pkg::FCTRL_MODE_BIT];
  assign link.debug_break_fault_disable = fault_ctrl_q[wave_guard_pkg::FCTRL_DBG_DIS_BIT];
  // Write-one-to-clear; a zero leaves the flag alone
  assign link.flag_clear = wr_status & reg_wdata_i[wave_guard_pkg::STAT_FLAG_BIT];
  assign link.update = update_i;

  fault_unit #(
    .EVENT_CHANNELS(EVENT_CHANNELS)
  ) u_fault (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .fault_event_i(fault_event_i),
    .debug_break_i(debug_break_i),
    .link(link)
  );

  // ****************************************************************
  // Buffered loads at UPDATE
  // ****************************************************************
  // A pending buffer moves to its active register on the timer's UPDATE only
  assign load_low = update_i & low_bufv_q;
  assign load_high = update_i & high_bufv_q & ~link.fault_hold;

  // ****************************************************************
  // Next-state values
  // ****************************************************************
  assign ctrl_d = wr_ctrl ? (reg_wdata_i & wave_guard_pkg::CTRL_WR_MASK) : ctrl_q;
  assign fault_mask_d = wr_mask ? reg_wdata_i : fault_mask_q;
  assign fault_ctrl_d = wr_fctrl ? (reg_wdata_i & wave_guard_pkg::FCTRL_WR_MASK) : fault_ctrl_q;
  assign dt_low_buf_d = (wr_low_buf | wr_both_buf) ? reg_wdata_i : dt_low_buf_q;
  assign dt_high_buf_d = (wr_high_buf | wr_both_buf) ? reg_wdata_i : dt_high_buf_q;

  // Direct writes win over the buffered copy in the same cycle
  assign dt_low_d = (wr_low | wr_both) ? reg_wdata_i : (load_low ? dt_low_buf_q : dt_low_q);
  assign dt_high_d = (wr_high | wr_both) ? reg_wdata_i :
                     ((load_high & ~pattern_mode_en) ? dt_high_buf_q : dt_high_q);

  // Valid bits: a fresh buffer write beats the load that empties it
  assign low_bufv_d = (wr_low_buf | wr_both_buf) |
                      (low_bufv_q & ~load_low & ~(wr_status & reg_wdata_i[wave_guard_pkg::STAT_LOW_BUFV_BIT]));
  assign high_bufv_d = (wr_high_buf | wr_both_buf) |
                       (high_bufv_q & ~load_high & ~(wr_status & reg_wdata_i[wave_guard_pkg::STAT_HIGH_BUFV_BIT]));

  // In pattern mode the high-side buffer carries the next override enables
  assign override_en_d = wr_override ? reg_wdata_i[PINS-1:0] :
                         ((load_high & pattern_mode_en) ? dt_high_buf_q[PINS-1:0] : override_en_q);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  assign status_byte = {5'h00, link.flag, high_bufv_q, low_bufv_q};

  always_comb
  begin
    rdata_d = wave_guard_pkg::RESET_BYTE;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        wave_guard_pkg::OFS_EXT_CTRL: rdata_d = ctrl_q;
        wave_guard_pkg::OFS_FAULT_MASK: rdata_d = fault_mask_q;
        wave_guard_pkg::OFS_FAULT_CTRL: rdata_d = fault_ctrl_q;
        wave_guard_pkg::OFS_STATUS: rdata_d = status_byte;
        wave_guard_pkg::OFS_DT_BOTH: rdata_d = dt_low_q;
        wave_guard_pkg::OFS_DT_BOTH_BUF: rdata_d = dt_low_buf_q;
        wave_guard_pkg::OFS_DT_LOW: rdata_d = dt_low_q;
        wave_guard_pkg::OFS_DT_HIGH: rdata_d = dt_high_q;
        wave_guard_pkg::OFS_DT_LOW_BUF: rdata_d = dt_low_buf_q;
        wave_guard_pkg::OFS_DT_HIGH_BUF: rdata_d = dt_high_buf_q;
        wave_guard_pkg::OFS_OVERRIDE_EN: rdata_d = override_en_q;
        default: rdata_d = wave_guard_pkg::RESET_BYTE; // Unmapped reads give zero
      endcase
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= wave_guard_pkg::RESET_BYTE;
      fault_mask_q <= wave_guard_pkg::RESET_BYTE;
      fault_ctrl_q <= wave_guard_pkg::RESET_BYTE;
      dt_low_q <= wave_guard_pkg::RESET_BYTE;
      dt_high_q <= wave_guard_pkg::RESET_BYTE;
      dt_low_buf_q <= wave_guard_pkg::RESET_BYTE;
      dt_high_buf_q <= wave_guard_pkg::RESET_BYTE;
      low_bufv_q <= 1'b0;
      high_bufv_q <= 1'b0;
      override_en_q <= '0;
      rdata_q <= wave_guard_pkg::RESET_BYTE;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      fault_mask_q <= fault_mask_d;
      fault_ctrl_q <= fault_ctrl_d;
      dt_low_q <= dt_low_d;
      dt_high_q <= dt_high_d;
      dt_low_buf_q <= dt_low_buf_d;
      dt_high_buf_q <= dt_high_buf_d;
      low_bufv_q <= low_bufv_d;
      high_bufv_q <= high_bufv_d;
      override_en_q <= override_en_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Port side events
  // ****************************************************************
  // Pattern reaches the port OUT register the cycle after the UPDATE load
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      port_load_q <= 1'b0;
      dir_restore_q <= '0;
      timer_err_q <= 1'b0;
    end
    else
    begin
      port_load_q <= load_low & pattern_mode_en;
      dir_restore_q <= link.fault_leave ? enabled_pins : '0;
      timer_err_q <= link.fault_enter;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o = rdata_q;

  // Dead-time generators are bypassed in pattern mode
  assign deadtime_channel_en_o = pattern_mode_en ? '0 : deadtime_channel_en;
  assign deadtime_wave_o = common_waveform_sel ? {CHANNELS{compare_wave_i[0]}} : compare_wave_i;
  assign deadtime_low_o = dt_low_q;
  assign deadtime_high_o = dt_high_q;

  // Override is gated by the port direction; this block never sets direction
  assign pin_override_o = pattern_mode_en ? (override_en_q & port_dir_i) : '0;
  assign pin_value_o = {PINS{compare_wave_i[0]}};
  assign port_out_load_o = port_load_q;
  assign port_out_data_o = dt_low_q[PINS-1:0];

  // Clear is held for the whole fault state; OUTPUT_OVERRIDE_ENABLE itself is untouched
  assign dir_clear_o = link.fault_hold ? enabled_pins : '0;
  assign dir_restore_o = dir_restore_q;
  assign timer_error_set_o = timer_err_q;

endmodule // waveform_pattern_fault_guard

// ---- tb/timer_port_model.sv ----
// Stand-in for the timer and port around the guard.
// Assumes the guard's clock and its synchronous active-high reset.
`timescale 1ns/1ps
module timer_port_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic [7:0] dir_init_i,
  input wire logic [7:0] dir_clear_i,
  output logic update_o,
  output logic [3:0] wave_o,
  output logic [7:0] port_dir_o
);
  // ****************************************************************
  // Free-running timer
  // ****************************************************************
  logic [3:0] count_q;
  logic [3:0] count_d;

  // Never halts, so UPDATE keeps arriving while a fault is held
  assign count_d = count_q + 4'h1;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      count_q <= 4'h0;
    else
      count_q <= count_d;
  end

  // One-cycle UPDATE every 4 cycles, or every 16 when slow
  assign update_o = slow_i ? (count_q == 4'hF) : (count_q[1:0] == 2'h3);
  assign wave_o = count_q;
  // Port keeps its own direction; the guard only masks pins off
  assign port_dir_o = dir_init_i & ~dir_clear_i;
endmodule // timer_port_model

// ---- tb/wave_guard_assertions.sv ----
// Port-level checks for the waveform guard.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module wave_guard_checker #(
  parameter int CHANNELS = 4,
  parameter int PINS = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic update_i,
  input wire logic [PINS-1:0] port_dir_i,
  input wire logic [CHANNELS-1:0] compare_wave_i,
  input wire logic [CHANNELS-1:0] deadtime_channel_en_o,
  input wire logic [CHANNELS-1:0] deadtime_wave_o,
  input wire logic [7:0] deadtime_low_o,
  input wire logic [PINS-1:0] pin_override_o,
  input wire logic [PINS-1:0] pin_value_o,
  input wire logic port_out_load_o,
  input wire logic [PINS-1:0] dir_clear_o,
  input wire logic [PINS-1:0] dir_restore_o,
  input wire logic timer_error_set_o
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_pin_value_a: assert property (pin_value_o == {PINS{compare_wave_i[0]}})
    else $error("pin value is not channel A");
  a_chan_a_kept: assert property (deadtime_wave_o[0] == compare_wave_i[0])
    else $error("channel A wave lost");
  a_override_dir_only: assert property ((pin_override_o & ~port_dir_i) == '0)
    else $error("override on an input pin");
  a_pattern_bypass: assert property ((|pin_override_o) |-> deadtime_channel_en_o == '0)
    else $error("dead-time active in pattern mode");
  a_error_one_pulse: assert property (timer_error_set_o |=> !timer_error_set_o)
    else $error("timer error not a pulse");
  a_restore_mask: assert property ((|dir_restore_o) |-> dir_clear_o == '0 && $past(dir_clear_o) == dir_restore_o)
    else $error("restore mask differs from cleared pins");
  a_leave_at_update: assert property (!$past(rst_i) && $fell(|dir_clear_o) |-> $past(update_i) || $past(reg_wr_i))
    else $error("fault left without UPDATE");
  a_hold_fault: assert property ((|dir_clear_o) && !update_i && !reg_wr_i |=> |dir_clear_o)
    else $error("fault dropped between updates");
  a_load_at_update: assert property (port_out_load_o |-> $past(update_i))
    else $error("pattern load without UPDATE");
  a_active_stable: assert property (!$past(rst_i) && !$past(update_i) && !$past(reg_wr_i) |-> $stable(deadtime_low_o))
    else $error("active register moved on its own");
endmodule // wave_guard_checker

bind waveform_pattern_fault_guard wave_guard_checker #(.CHANNELS(CHANNELS), .PINS(PINS)) u_wave_guard_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .update_i(update_i), .port_dir_i(port_dir_i),
  .compare_wave_i(compare_wave_i), .deadtime_channel_en_o(deadtime_channel_en_o), .deadtime_wave_o(deadtime_wave_o),
  .deadtime_low_o(deadtime_low_o), .pin_override_o(pin_override_o), .pin_value_o(pin_value_o),
  .port_out_load_o(port_out_load_o), .dir_clear_o(dir_clear_o), .dir_restore_o(dir_restore_o),
  .timer_error_set_o(timer_error_set_o));

// ---- tb/testbench.sv ----
// Self-checking bench for the waveform guard with its timer and port stand-in.
// Assumes a 200 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module testbench;
  logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, ext_lock_i, debug_break_i, update_i, slow, rd_pend;
  logic port_out_load_o, timer_error_set_o;
  logic [3:0] reg_addr_i, compare_wave_i, deadtime_channel_en_o, deadtime_wave_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, fault_event_i, port_dir_i, dir_init, r, deadtime_low_o, deadtime_high_o;
  logic [7:0] pin_override_o, pin_value_o, port_out_data_o, dir_clear_o, dir_restore_o;
  logic [7:0] exp_q[$];
  logic [3:0] ofs[4] = '{4'h0, 4'h2, 4'h3, 4'hD};
  int n_errors, n_compared, k;
  logic terr;

  waveform_pattern_fault_guard u_waveform_pattern_fault_guard (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ext_lock_i(ext_lock_i), .compare_wave_i(compare_wave_i), .update_i(update_i),
    .fault_event_i(fault_event_i), .debug_break_i(debug_break_i), .port_dir_i(port_dir_i),
    .deadtime_channel_en_o(deadtime_channel_en_o), .deadtime_wave_o(deadtime_wave_o),
    .deadtime_low_o(deadtime_low_o), .deadtime_high_o(deadtime_high_o), .pin_override_o(pin_override_o),
    .pin_value_o(pin_value_o), .port_out_load_o(port_out_load_o), .port_out_data_o(port_out_data_o),
    .dir_clear_o(dir_clear_o), .dir_restore_o(dir_restore_o), .timer_error_set_o(timer_error_set_o));
  timer_port_model u_timer_port_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
    .dir_init_i(dir_init), .dir_clear_i(dir_clear_o), .update_o(update_i), .wave_o(compare_wave_i),
    .port_dir_o(port_dir_i));

  // ****************************************************************
  // Clock, tasks and read monitor
  // ****************************************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  // One-cycle event; the timer error pulse stands only in the cycle after the event is taken
  task automatic hit(input logic [7:0] ev);
    @(posedge core_clk_i);
    fault_event_i <= ev;
    @(posedge core_clk_i);
    fault_event_i <= 8'h00;
    #1;
    terr = timer_error_set_o;
    @(posedge core_clk_i);
    #1;
  endtask

  // Bounded wait for a restore pulse (0) or a pattern load (1)
  task automatic wait_for(input int which);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk_i);
      #1;
      if (which == 0 ? dir_restore_o != 8'h00 : port_out_load_o === 1'b1)
        break;
    end
    if (i == 40)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk_i)
  begin
    if (rd_pend)
      chk("read data", exp_q.pop_front(), reg_rdata_o);
    rd_pend <= reg_rd_i;
  end

  initial
  begin
    #100000;
    n_errors++;
    end_of_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {reg_wr_i, reg_rd_i, ext_lock_i, debug_break_i, slow, rd_pend} = 6'h00;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    fault_event_i = 8'h00;
    dir_init = 8'h0F;
    rst_i = 1'b1;
    n_errors = 0;
    n_compared = 0;
    k = $urandom(632);
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    r = 8'($urandom()) & 8'h3F;
    wr(4'h0, r);
    rd(4'h0, r);
    ext_lock_i <= 1'b1;
    wr(4'h0, ~r);
    wr(4'h2, 8'hFF);
    wr(4'hC, 8'hFF);
    ext_lock_i <= 1'b0;
    rd(4'h0, r);
    rd(4'h2, 8'h00);
    rd(4'hC, 8'h00);
    $display("registers and lock done");
    wr(4'h0, 8'h10);
    #1;
    chk("common wave", {4'h0, {4{compare_wave_i[0]}}}, {4'h0, deadtime_wave_o});
    wr(4'h0, 8'h2F);
    #1;
    chk("channel enables", 8'h00, {4'h0, deadtime_channel_en_o});
    wr(4'h0, 8'h03);
    #1;
    chk("channel enables", 8'h03, {4'h0, deadtime_channel_en_o});
    chk("own wave", {4'h0, compare_wave_i}, {4'h0, deadtime_wave_o});
    $display("waveform selection done");
    wr(4'h2, 8'hFF);
    for (k = 0; k < 3; k++)
    begin
      wr(4'h3, 8'(k));
      hit(8'($urandom()) | 8'h01);
      chk("direction clear", 8'h00, dir_clear_o);
      rd(4'h4, 8'h00);
    end
    k = $urandom() % 8;
    wr(4'h2, 8'h01 << k);
    wr(4'h3, 8'h03);
    hit(~(8'h01 << k));
    chk("timer error", 8'h00, 8'(terr));
    rd(4'h4, 8'h00);
    hit(8'h01 << k);
    chk("direction clear", 8'h0F, dir_clear_o);
    chk("timer error", 8'h01, 8'(terr));
    wr(4'hC, 8'hAA);
    repeat (12) @(posedge core_clk_i);
    #1;
    chk("direction clear held", 8'h0F, dir_clear_o);
    rd(4'hC, 8'h00);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h04);
    wr(4'h4, 8'h04);
    wait_for(0);
    chk("direction restore", 8'h0F, dir_restore_o);
    rd(4'h4, 8'h00);
    $display("latched fault done");
    wr(4'h3, 8'h07);
    slow <= 1'b1;
    debug_break_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    debug_break_i <= 1'b0;
    #1;
    chk("direction clear", 8'h0F, dir_clear_o);
    wait_for(0);
    chk("direction restore", 8'h0F, dir_restore_o);
    wr(4'h4, 8'h04);
    wr(4'h3, 8'h17);
    debug_break_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    debug_break_i <= 1'b0;
    #1;
    chk("direction clear", 8'h00, dir_clear_o);
    rd(4'h4, 8'h00);
    $display("debug break done");
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h20);
    wr(4'hC, 8'hFF);
    r = 8'($urandom());
    wr(4'hA, r);
    wait_for(1);
    chk("pattern", r, port_out_data_o);
    chk("pin override", 8'h0F, pin_override_o);
    // Outside pattern mode both buffers move to the active dead-time registers at UPDATE
    wr(4'h0, 8'h00);
    wr(4'h7, ~r);
    repeat (17) @(posedge core_clk_i);
    #1;
    chk("dead-time high", ~r, deadtime_high_o);
    chk("dead-time low", ~r, deadtime_low_o);
    rd(4'h4, 8'h00);
    $display("pattern done");
    end_of_test();
  end
endmodule // testbench
